// *** design/mcp_misc_control.sv ***
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/10ps
`include "mcp_params.svh"

// Behaviour
// - RAM self-test error forces accumulation off unless disabled.
// - Checksum error forces accumulation off unless disabled.
// - Power-down forces accumulation off unless disabled.
// - Shutdown only gates outputs, enables stay unchanged.
// - Polarity bit sets interrupt pin idle and active.
// - Burst bit zero allows serial burst writes.
// - Self-adapt bit picks first-only or every-time detection.
// - Sixteen byte slots, four per register, low first.
// - Top two bits select pin function.
// - Seven pin bytes over two configuration registers.
// - All-zero pin byte leaves pin undriven.
// - Group 0 zero-crossing, overflow or class one.
// - Group 1 data refresh and waveform events.
// - Group 2 current and voltage limit events.
// - Group 3 fault, power-down and phase events.
// - Four classes group the flags as listed.
// - Groups 4 and 5 select classes and pairs.
// - Group 6 selects triples, else all classes.
// - Group 7 routes waveform master select, clock, data.
// - Read-only hardware version register.
// - Flags set by events, cleared writing one.
module mcp_misc_control #(
  parameter logic [31:0] HW_VERSION = 32'h0000_0001  // Arbitrary value.
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire logic [9:0]   i_avs_address,
  input  wire logic         i_avs_read,
  input  wire logic         i_avs_write,
  input  wire logic [31:0]  i_avs_writedata,
  input  wire logic [3:0]   i_avs_byteenable,
  output logic [31:0]       o_avs_readdata,
  output logic              o_avs_waitrequest,
  input  wire logic [31:0]  i_irq_events,
  input  wire logic         i_ram_selftest_err,
  input  wire logic         i_checksum_err,
  input  wire logic         i_powerdown,
  input  wire logic         i_metering_reenable,
  input  wire logic [8:0]   i_wave_store_count,
  input  wire logic         i_energy_pulse_out_1,
  input  wire logic         i_energy_pulse_out_2,
  input  wire logic         i_energy_upload,
  input  wire logic         i_wave_master_chip_select,
  input  wire logic         i_wave_master_clock,
  input  wire logic         i_wave_master_data_out,
  output logic              o_energy_run,
  output logic              o_serial_burst_write_allow,
  output logic              o_serial_baud_every_time,
  output logic [127:0]      o_block_read_slots,
  output logic [6:0]        o_pin_out,
  output logic [6:0]        o_pin_oe_n
);

  // ****************************************************************
  // Register storage.
  // ****************************************************************
  logic [31:0]                  irq_flags_reg;
  logic [31:0]                  irq_enable_reg;
  logic [5:0]                   misc_ctl_reg;
  logic [31:0]                  blk_reg [0:3];
  logic [31:0]                  pinsel_lo_reg;
  logic [31:0]                  pinsel_hi_reg;
  logic                         shutdown_reg;
  logic [6:0]                   pin_out_reg;
  logic [6:0]                   pin_oe_n_reg;
  mcp_pkg::mcp_bus_state_t      bus_state_reg;
  logic [31:0]                  readdata_reg;

  logic [7:0]                   reg_idx;
  logic                         req;
  logic                         wr_take;
  logic [31:0]                  be_mask;
  logic [31:0]                  irq_pending;
  logic                         fault_now;
  logic [6:0]                   pin_drive;
  logic [6:0]                   pin_level;
  logic [55:0]                  pin_cfg;

  // Byte-lane mask from the Avalon byte enables.
  function automatic logic [31:0] mcp_lanes(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // Merge of write data into a register under lanes and a writable mask.
  function automatic logic [31:0] mcp_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [31:0] lanes, input logic [31:0] wmask);
    return (old & ~(lanes & wmask)) | (wd & lanes & wmask);
  endfunction

  // ****************************************************************
  // Avalon slave handshake.
  // ****************************************************************

  // Every request waits exactly one cycle, so read data can be registered.
  assign reg_idx           = i_avs_address[9:2];
  assign req               = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & (bus_state_reg == mcp_pkg::MCP_BUS_IDLE);
  assign wr_take           = i_avs_write & (bus_state_reg == mcp_pkg::MCP_BUS_ACK);
  assign be_mask           = mcp_lanes(i_avs_byteenable);
  assign o_avs_readdata    = readdata_reg;

  // The acknowledge state lasts one cycle, then the master must release.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bus_state_reg <= mcp_pkg::MCP_BUS_IDLE;
    end else if (req && bus_state_reg == mcp_pkg::MCP_BUS_IDLE) begin
      bus_state_reg <= mcp_pkg::MCP_BUS_ACK;
    end else begin
      bus_state_reg <= mcp_pkg::MCP_BUS_IDLE;
    end
  end

  // Read data are captured in the wait cycle; unmapped offsets read zero.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      readdata_reg <= `MCP_RESET_WORD;
    end else if (i_avs_read && bus_state_reg == mcp_pkg::MCP_BUS_IDLE) begin
      if (reg_idx == `MCP_IDX_IRQ_FLAGS) begin
        readdata_reg <= irq_flags_reg;
      end else if (reg_idx == `MCP_IDX_IRQ_ENABLE) begin
        readdata_reg <= irq_enable_reg;
      end else if (reg_idx == `MCP_IDX_MISC) begin
        readdata_reg <= {7'h00, i_wave_store_count, 10'h000, misc_ctl_reg};
      end else if (reg_idx == `MCP_IDX_BLK0) begin
        readdata_reg <= blk_reg[0];
      end else if (reg_idx == `MCP_IDX_BLK1) begin
        readdata_reg <= blk_reg[1];
      end else if (reg_idx == `MCP_IDX_BLK2) begin
        readdata_reg <= blk_reg[2];
      end else if (reg_idx == `MCP_IDX_BLK3) begin
        readdata_reg <= blk_reg[3];
      end else if (reg_idx == `MCP_IDX_PINSEL_LO) begin
        readdata_reg <= pinsel_lo_reg;
      end else if (reg_idx == `MCP_IDX_PINSEL_HI) begin
        readdata_reg <= pinsel_hi_reg;
      end else if (reg_idx == `MCP_IDX_VERSION) begin
        readdata_reg <= HW_VERSION;
      end else begin
        readdata_reg <= `MCP_RESET_WORD;
      end
    end
  end

  // ****************************************************************
  // Writable registers.
  // ****************************************************************

  // Enables, control bits and configuration bytes; writes to the version
  // register and to reserved bits are dropped.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      irq_enable_reg <= `MCP_RESET_WORD;
      misc_ctl_reg   <= `MCP_RESET_CTL;
      pinsel_lo_reg  <= `MCP_RESET_WORD;
      pinsel_hi_reg  <= `MCP_RESET_WORD;
    end else if (wr_take) begin
      if (reg_idx == `MCP_IDX_IRQ_ENABLE) begin
        irq_enable_reg <= mcp_merge(irq_enable_reg, i_avs_writedata, be_mask, `MCP_FLAG_MASK);
      end else if (reg_idx == `MCP_IDX_MISC && i_avs_byteenable[0]) begin
        misc_ctl_reg <= i_avs_writedata[5:0];
      end else if (reg_idx == `MCP_IDX_PINSEL_LO) begin
        pinsel_lo_reg <= mcp_merge(pinsel_lo_reg, i_avs_writedata, be_mask, 32'hFFFF_FFFF);
      end else if (reg_idx == `MCP_IDX_PINSEL_HI) begin
        pinsel_hi_reg <= mcp_merge(pinsel_hi_reg, i_avs_writedata, be_mask, `MCP_PINSEL_HI_MASK);
      end
    end
  end

  // Block-read slots, four bytes to a register with the lowest slot in the low byte.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      for (int k = 0; k < 4; k++) begin
        blk_reg[k] <= `MCP_RESET_WORD;
      end
    end else if (wr_take && reg_idx >= `MCP_IDX_BLK0 && reg_idx <= `MCP_IDX_BLK3) begin
      blk_reg[reg_idx[1:0] - 2'd1] <= mcp_merge(blk_reg[reg_idx[1:0] - 2'd1], i_avs_writedata,
                                                be_mask, 32'hFFFF_FFFF);
    end
  end

  // Sticky flags: an event in the cycle of its write-one clear still sets it.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      irq_flags_reg <= `MCP_RESET_WORD;
    end else begin
      if (wr_take && reg_idx == `MCP_IDX_IRQ_FLAGS) begin
        irq_flags_reg <= ((irq_flags_reg & ~(i_avs_writedata & be_mask)) | i_irq_events)
                         & `MCP_FLAG_MASK;
      end else begin
        irq_flags_reg <= (irq_flags_reg | i_irq_events) & `MCP_FLAG_MASK;
      end
    end
  end

  // ****************************************************************
  // Forced energy shutdown.
  // ****************************************************************

  // A bit at zero arms protection for its fault.
  assign fault_now = (i_ram_selftest_err & ~misc_ctl_reg[`MCP_MISC_RAM_BIT])
                   | (i_checksum_err     & ~misc_ctl_reg[`MCP_MISC_CK_BIT])
                   | (i_powerdown        & ~misc_ctl_reg[`MCP_MISC_PD_BIT]);

  // The shutdown latches: a fault that clears does not restart metering,
  // only the host rewriting the metering enables does. The enables themselves
  // are never touched, the block only withholds its run output and the energy pulses on the pins.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      shutdown_reg <= 1'b0;
    end else if (fault_now) begin
      shutdown_reg <= 1'b1;
    end else if (i_metering_reenable) begin
      shutdown_reg <= 1'b0;
    end
  end

  assign o_energy_run = ~shutdown_reg;

  // ****************************************************************
  // Serial options and block-read slots.
  // ****************************************************************
  assign o_serial_burst_write_allow = ~misc_ctl_reg[`MCP_MISC_BURST_BIT];
  assign o_serial_baud_every_time   = misc_ctl_reg[`MCP_MISC_BAUD_BIT];
  assign o_block_read_slots         = {blk_reg[3], blk_reg[2], blk_reg[1], blk_reg[0]};

  // ****************************************************************
  // Multifunction pins.
  // ****************************************************************

  // Only enabled flags reach a pin; the class grouping lives in the router.
  assign irq_pending = irq_flags_reg & irq_enable_reg;
  assign pin_cfg     = {pinsel_hi_reg[23:0], pinsel_lo_reg};

  for (genvar p = 0; p < 7; p++) begin : g_pin
    mcp_pin_route u_route (
      .i_cfg        (pin_cfg[p*8 +: 8]),
      .i_pending    (irq_pending),
      .i_polarity   (misc_ctl_reg[`MCP_MISC_POL_BIT]),
      .i_pulse1     (i_energy_pulse_out_1 & ~shutdown_reg),
      .i_pulse2     (i_energy_pulse_out_2 & ~shutdown_reg),
      .i_upload     (i_energy_upload),
      .i_wave_cs    (i_wave_master_chip_select),
      .i_wave_clk   (i_wave_master_clock),
      .i_wave_dout  (i_wave_master_data_out),
      .o_drive      (pin_drive[p]),
      .o_level      (pin_level[p])
    );
  end

  // Pins are registered so they never glitch while the configuration decodes.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pin_out_reg  <= 7'h00;
      pin_oe_n_reg <= 7'h7F;
    end else begin
      pin_out_reg  <= pin_level;
      pin_oe_n_reg <= ~pin_drive;
    end
  end

  assign o_pin_out  = pin_out_reg;
  assign o_pin_oe_n = pin_oe_n_reg;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  // Checks stay silent during reset, since every register is forced there.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  property p_ram_shutdown;
    i_ram_selftest_err && !misc_ctl_reg[`MCP_MISC_RAM_BIT] |=> !o_energy_run;
  endproperty
  a_ram_shutdown: assert property (p_ram_shutdown) else $error("RAM fault did not stop metering");

  property p_ck_shutdown;
    i_checksum_err && !misc_ctl_reg[`MCP_MISC_CK_BIT] |=> !o_energy_run;
  endproperty
  a_ck_shutdown: assert property (p_ck_shutdown) else $error("Checksum fault did not stop metering");

  property p_pd_shutdown;
    i_powerdown && !misc_ctl_reg[`MCP_MISC_PD_BIT] |=> !o_energy_run;
  endproperty
  a_pd_shutdown: assert property (p_pd_shutdown) else $error("Power-down did not stop metering");

  property p_no_resume;
    !o_energy_run && !i_metering_reenable |=> !o_energy_run;
  endproperty
  a_no_resume: assert property (p_no_resume) else $error("Metering resumed without host");

  // The burst permission follows the bit written, inverted, one cycle later.
  property p_burst;
    wr_take && reg_idx == `MCP_IDX_MISC && i_avs_byteenable[0]
      |=> o_serial_burst_write_allow == !$past(i_avs_writedata[`MCP_MISC_BURST_BIT]);
  endproperty
  a_burst: assert property (p_burst) else $error("Burst permission wrong");

  property p_flag_set;
    i_irq_events[0] |=> irq_flags_reg[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("Event flag not set");

  property p_flag_hold;
    irq_flags_reg[1] && !(wr_take && reg_idx == `MCP_IDX_IRQ_FLAGS) |=> irq_flags_reg[1];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("Flag lost without clear");

  property p_zero_cfg_hiz;
    pinsel_lo_reg[7:0] == 8'h00 |=> o_pin_oe_n[0];
  endproperty
  a_zero_cfg_hiz: assert property (p_zero_cfg_hiz) else $error("Unconfigured pin driven");

  property p_pulse1_route;
    pinsel_lo_reg[7:6] == 2'b10 && !shutdown_reg |=> !o_pin_oe_n[0] && o_pin_out[0] == $past(i_energy_pulse_out_1);
  endproperty
  a_pulse1_route: assert property (p_pulse1_route) else $error("Pulse 1 not on pin 0");

  // Pulses are withheld while shut down, yet the pin keeps being driven low.
  property p_pulse_gated;
    pinsel_lo_reg[7:6] == 2'b10 && shutdown_reg |=> !o_pin_oe_n[0] && !o_pin_out[0];
  endproperty
  a_pulse_gated: assert property (p_pulse_gated) else $error("Pulse passed during shutdown");

  property p_version;
    i_avs_read && reg_idx == `MCP_IDX_VERSION && o_avs_waitrequest
      |=> !o_avs_waitrequest && o_avs_readdata == HW_VERSION;
  endproperty
  a_version: assert property (p_version) else $error("Version read wrong");

  c_shutdown: cover property (fault_now ##1 !o_energy_run ##[1:20] o_energy_run);
  c_flag_clear: cover property (irq_flags_reg[0] ##1 wr_take && reg_idx == `MCP_IDX_IRQ_FLAGS ##1 !irq_flags_reg[0]);
  c_pin_irq: cover property (pinsel_lo_reg[7:0] == 8'h07 && !o_pin_oe_n[0] && o_pin_out[0]);
  // A gated pulse pin and a waveform master pin are the rarer routes.
  c_pulse_gated: cover property (pinsel_lo_reg[7:6] == 2'b10 && shutdown_reg);
  c_wave_pin: cover property (pinsel_lo_reg[7:3] == 5'b00111 && !o_pin_oe_n[0]);

endmodule

// *** design/mcp_params.svh ***
`ifndef MCP_PARAMS_SVH
`define MCP_PARAMS_SVH

// ****************************************************************
// Register indices; the byte address on the bus is four times these.
// ****************************************************************
`define MCP_IDX_IRQ_FLAGS     8'h72
`define MCP_IDX_IRQ_ENABLE    8'h73
`define MCP_IDX_MISC          8'h75
`define MCP_IDX_BLK0          8'h79
`define MCP_IDX_BLK1          8'h7A
`define MCP_IDX_BLK2          8'h7B
`define MCP_IDX_BLK3          8'h7C
`define MCP_IDX_PINSEL_LO     8'h7D
`define MCP_IDX_PINSEL_HI     8'h7E
`define MCP_IDX_VERSION       8'h7F

// ****************************************************************
// Field positions of the system control register.
// ****************************************************************
`define MCP_MISC_RAM_BIT      5
`define MCP_MISC_CK_BIT       4
`define MCP_MISC_PD_BIT       3
`define MCP_MISC_POL_BIT      2
`define MCP_MISC_BURST_BIT    1
`define MCP_MISC_BAUD_BIT     0
`define MCP_MISC_CNT_LSB      16
`define MCP_MISC_CNT_MSB      24

// ****************************************************************
// Reset values and writable masks.
// ****************************************************************
`define MCP_RESET_WORD        32'h0000_0000
`define MCP_RESET_CTL         6'h00
`define MCP_FLAG_MASK         32'h3FF9_FFFF
`define MCP_PINSEL_HI_MASK    32'h00FF_FFFF

// ****************************************************************
// Interrupt class membership over the flag word.
// ****************************************************************
`define MCP_CLASS1_MASK       32'h3000_0600
`define MCP_CLASS2_MASK       32'h0000_81FC
`define MCP_CLASS3_MASK       32'h0FF0_0000
`define MCP_CLASS4_MASK       32'h0009_7803

`endif

// *** design/mcp_pkg.sv ***
package mcp_pkg;

  // Pin function selected by the two top bits of a configuration byte.
  typedef enum logic [1:0] {
    MCP_FN_IRQ    = 2'b00,
    MCP_FN_PULSE2 = 2'b01,
    MCP_FN_PULSE1 = 2'b10,
    MCP_FN_UPLOAD = 2'b11
  } mcp_func_t;

  // Bus answer state: a request is always held one wait cycle.
  typedef enum logic {
    MCP_BUS_IDLE = 1'b0,
    MCP_BUS_ACK  = 1'b1
  } mcp_bus_state_t;

endpackage

// *** design/mcp_pin_route.sv ***
`timescale 1ns/10ps
`include "mcp_params.svh"

// Decodes one configuration byte into a drive enable and a pin level.
module mcp_pin_route (
  input  wire logic [7:0]  i_cfg,
  input  wire logic [31:0] i_pending,
  input  wire logic        i_polarity,
  input  wire logic        i_pulse1,
  input  wire logic        i_pulse2,
  input  wire logic        i_upload,
  input  wire logic        i_wave_cs,
  input  wire logic        i_wave_clk,
  input  wire logic        i_wave_dout,
  output logic             o_drive,
  output logic             o_level
);

  // Mask of the four classes, class 1 in bit 0.
  function automatic logic [31:0] mcp_class_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = 32'h0000_0000;
    if (sel[0]) m = m | `MCP_CLASS1_MASK;
    if (sel[1]) m = m | `MCP_CLASS2_MASK;
    if (sel[2]) m = m | `MCP_CLASS3_MASK;
    if (sel[3]) m = m | `MCP_CLASS4_MASK;
    return m;
  endfunction

  // Single flag of groups 0 to 3, one row of bit positions per group.
  function automatic logic [31:0] mcp_single(input logic [1:0] grp, input logic [2:0] code);
    logic [4:0] pos [0:3][0:7];
    logic [31:0] m;
    pos[0] = '{5'd0, 5'd10, 5'd9, 5'd10, 5'd9, 5'd28, 5'd29, 5'd0};
    pos[1] = '{5'd6, 5'd5, 5'd4, 5'd3, 5'd2, 5'd7, 5'd8, 5'd15};
    pos[2] = '{5'd25, 5'd24, 5'd23, 5'd22, 5'd21, 5'd20, 5'd27, 5'd26};
    pos[3] = '{5'd12, 5'd13, 5'd19, 5'd16, 5'd1, 5'd14, 5'd0, 5'd11};
    m = 32'h0000_0001 << pos[grp][code];
    return m;
  endfunction

  logic [31:0] sel_mask;
  logic        irq_drive;
  logic        wave_drive;
  logic        wave_level;

  // Selection of the flags that one interrupt-routed pin watches.
  always_comb begin
    sel_mask  = 32'h0000_0000;
    irq_drive = 1'b1;
    case (i_cfg[5:3])
      3'd0: begin
        if (i_cfg[2:0] == 3'd0) irq_drive = 1'b0;
        else if (i_cfg[2:0] == 3'd7) sel_mask = mcp_class_mask(4'b0001);
        else sel_mask = mcp_single(2'd0, i_cfg[2:0]);
      end
      3'd1: sel_mask = mcp_single(2'd1, i_cfg[2:0]);
      3'd2: sel_mask = mcp_single(2'd2, i_cfg[2:0]);
      3'd3: sel_mask = mcp_single(2'd3, i_cfg[2:0]);
      3'd4: begin
        if (i_cfg[2:0] < 3'd3) sel_mask = mcp_class_mask(4'b0001 << i_cfg[1:0]);
        else sel_mask = mcp_class_mask(4'b1000);
      end
      3'd5: begin
        case (i_cfg[2:0])
          3'd0: sel_mask = mcp_class_mask(4'b0100);
          3'd1: sel_mask = mcp_class_mask(4'b0011);
          3'd2: sel_mask = mcp_class_mask(4'b0101);
          3'd3: sel_mask = mcp_class_mask(4'b1001);
          3'd4: sel_mask = mcp_class_mask(4'b0110);
          3'd5: sel_mask = mcp_class_mask(4'b1010);
          3'd6: sel_mask = mcp_class_mask(4'b1100);
          default: sel_mask = mcp_class_mask(4'b1111);
        endcase
      end
      3'd6: begin
        case (i_cfg[2:0])
          3'd0: sel_mask = mcp_class_mask(4'b0111);
          3'd1: sel_mask = mcp_class_mask(4'b1011);
          3'd2: sel_mask = mcp_class_mask(4'b1101);
          3'd3: sel_mask = mcp_class_mask(4'b1110);
          default: sel_mask = mcp_class_mask(4'b1111);
        endcase
      end
      default: irq_drive = 1'b0;
    endcase
  end

  // Waveform master signals on group 7; other codes leave the pin undriven.
  always_comb begin
    wave_drive = 1'b1;
    wave_level = 1'b0;
    case (i_cfg[2:0])
      3'd1: wave_level = i_wave_cs;
      3'd2: wave_level = i_wave_clk;
      3'd4: wave_level = i_wave_dout;
      default: wave_drive = 1'b0;
    endcase
  end

  // Function select by the two top bits; the low bits only matter for 00.
  always_comb begin
    o_drive = 1'b1;
    o_level = 1'b0;
    case (mcp_pkg::mcp_func_t'(i_cfg[7:6]))
      mcp_pkg::MCP_FN_PULSE1: o_level = i_pulse1;
      mcp_pkg::MCP_FN_PULSE2: o_level = i_pulse2;
      mcp_pkg::MCP_FN_UPLOAD: o_level = i_upload;
      default: begin
        if (i_cfg[5:3] == 3'd7) begin
          o_drive = wave_drive;
          o_level = wave_level;
        end else begin
          o_drive = irq_drive;
          o_level = (|(i_pending & sel_mask)) ^ i_polarity;
        end
      end
    endcase
  end

endmodule

// *** test/mcp_host.sv ***
`timescale 1ns/10ps
// ****
// Host pins
// ****
// The host sees a driven level; a released pin has no pull, so it flips.
module mcp_host (
  input  wire logic       i_clk,
  input  wire logic [6:0] i_q,
  input  wire logic [6:0] i_oe_n,
  output logic      [6:0] o_lvl
);
  logic [6:0] last_reg = 7'h00;
  assign o_lvl = (i_q & ~i_oe_n) | (~last_reg & i_oe_n);
  // Keep the last level so a floating pin never looks stable.
  always @(posedge i_clk) last_reg <= o_lvl;
endmodule

// *** test/mcp_misc_control_tb.sv ***
`timescale 1ns/10ps
`include "mcp_params.svh"
// ****
// Bench
// ****
module mcp_misc_control_tb;
  localparam logic [31:0] VER = 32'h0000_5A3C;  // Arbitrary value.
  logic         i_clk, i_reset, rd, wr, wt, rn, run, bst, bd;
  logic [9:0]   adr;
  logic [31:0]  wd, rdat, ev, e, w, sn, pd;
  logic [5:0]   s;
  logic [2:0]   f;
  logic [7:0]   c;
  logic [1:0]   x;
  logic [127:0] sl;
  logic [6:0]   q, oe_n, lv;
  int           fails = 0, checks = 0, cyc = 0, k, p;
  mcp_misc_control #(.HW_VERSION(VER)) uut (.i_clk(i_clk), .i_reset(i_reset), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wt), .i_irq_events(ev), .i_ram_selftest_err(f[0]),
    .i_checksum_err(f[1]), .i_powerdown(f[2]), .i_metering_reenable(rn), .i_wave_store_count(9'h1A5),
    .i_energy_pulse_out_1(s[0]), .i_energy_pulse_out_2(s[1]), .i_energy_upload(s[2]),
    .i_wave_master_chip_select(s[3]), .i_wave_master_clock(s[4]), .i_wave_master_data_out(s[5]),
    .o_energy_run(run), .o_serial_burst_write_allow(bst), .o_serial_baud_every_time(bd),
    .o_block_read_slots(sl), .o_pin_out(q), .o_pin_oe_n(oe_n));
  mcp_host host (.i_clk(i_clk), .i_q(q), .i_oe_n(oe_n), .o_lvl(lv));
  // Compare and count.
  task automatic chk(input string n, input logic [31:0] v, input logic [31:0] ex);
    checks++;
    if (v !== ex) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, ex, v);
    end
  endtask
  // One bus cycle, held until waitrequest is sampled low at a rising edge;
  // read data are taken at that same edge, then the request is released.
  task automatic bus(input logic wn, input logic [7:0] i, input logic [31:0] d);
    adr <= {i, 2'b00};
    wr <= wn;
    rd <= !wn;
    wd <= d;
    do begin
      @(posedge i_clk);
    end while (wt !== 1'b0);
    sn = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge i_clk);
  endtask
  // Verdict.
  task automatic tally_and_finish;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Flags behind an interrupt code; the class word holds one nibble per code.
  function automatic logic [31:0] imask(input logic [5:0] a);
    logic [63:0] t;
    logic [31:0] m;
    logic [7:0]  n;
    logic [3:0]  g;
    t = '1;
    m = 32'h0;
    case (a[5:3])
      3'd0: {t, m} = {64'hFF1D1C090A090AFF, 32'h1000_0000};
      3'd1: t = 64'h0F08070203040506;
      3'd2: t = 64'h1A1B141516171819;
      3'd3: t = 64'h0B000E0110130D0C;
      3'd4: m = 32'h8888_8421;
      3'd5: m = 32'hFCA6_9534;
      default: m = 32'hFFFF_EDB7;
    endcase
    n = t[{a[2:0], 3'b000} +: 8];
    g = m[{a[2:0], 2'b00} +: 4];
    return (n == 8'hFF ? 32'h0 : 32'h1 << n) | {32{g[0]}} & `MCP_CLASS1_MASK | {32{g[1]}} & `MCP_CLASS2_MASK
      | {32{g[2]}} & `MCP_CLASS3_MASK | {32{g[3]}} & `MCP_CLASS4_MASK;
  endfunction
  // Drive enable and level of one pin for a configuration byte.
  function automatic logic [1:0] epin(input logic [7:0] a, input logic [31:0] fl, input logic pl);
    if (a[7:6] != 2'b00) return {1'b1, a[7:6] == 2'b10 ? s[0] : a[7:6] == 2'b01 ? s[1] : s[2]};
    if (a[5:3] == 3'd7) return a[2:0] == 3'd1 ? {1'b1, s[3]} : a[2:0] == 3'd2 ? {1'b1, s[4]}
      : a[2:0] == 3'd4 ? {1'b1, s[5]} : 2'b00;
    return a == 8'h00 ? 2'b00 : {1'b1, |(imask(a[5:0]) & fl) ^ pl};
  endfunction
  // Clock of 40 ns.
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  // A hang counts as a mismatch; the tests need under 2500 cycles.
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      tally_and_finish();
    end
  end
  // Reset, then the tests in turn.
  initial begin
    {rd, wr, rn, adr, wd, ev, f, s} <= '0;
    i_reset <= 1'b1;
    k = $urandom(10655);
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    for (k = 0; k < 14; k++) begin
      bus(1'b0, 8'h72 + 8'(k), 32'h0);
      chk("reset", sn, k == 3 ? 32'h01A5_0000 : k == 13 ? VER : 32'h0);
    end
    bus(1'b1, 8'h7F, 32'hFFFF_FFFF);
    bus(1'b0, 8'h7F, 32'h0);
    chk("version", sn, VER);
    bus(1'b1, 8'h7E, 32'hFFFF_FFFF);
    bus(1'b0, 8'h7E, 32'h0);
    chk("pin high", sn, 32'h00FF_FFFF);
    for (k = 0; k < 4; k++) begin
      w = $urandom;
      bus(1'b1, 8'h79 + 8'(k), w);
      @(negedge i_clk);
      chk("slots", sl[32*k +: 32], w);
      @(posedge i_clk);
    end
    $display("test registers done");
    for (k = 0; k < 6; k++) begin
      bus(1'b1, 8'h75, k > 2 ? 32'h20 >> (k - 3) : 32'h0);
      f <= 3'b001 << (k % 3);
      repeat (2) @(posedge i_clk);
      f <= 3'b000;
      repeat (3) @(negedge i_clk);
      chk("run fault", run, k > 2);
      @(posedge i_clk) rn <= 1'b1;
      @(posedge i_clk) rn <= 1'b0;
      @(negedge i_clk);
      chk("run back", run, 1'b1);
      @(posedge i_clk);
    end
    $display("test shutdown done");
    bus(1'b1, 8'h73, 32'hFFFF_FFFF);
    for (k = 0; k < 48; k++) begin
      c = k < 8 ? {5'b00111, 3'(k)} : k == 8 ? 8'h00 : 8'($urandom);
      p = $urandom % 7;
      e = $urandom;
      w = $urandom & 32'hFFFF_FFC7;
      s <= 6'($urandom);
      bus(1'b1, 8'h75, w);  // Self-adapt may be set; the fault-disable bits stay clear.
      bus(1'b1, 8'h7D, p < 4 ? {24'h0, c} << 8 * p : 32'h0);
      bus(1'b1, 8'h7E, p < 4 ? 32'h0 : {24'h0, c} << 8 * (p - 4));
      ev <= e;
      @(posedge i_clk) ev <= 32'h0;
      bus(1'b0, 8'h72, 32'h0);
      pd = e & `MCP_FLAG_MASK;
      chk("flags", sn, pd);
      bus(1'b1, 8'h72, 32'h0);
      repeat (2) begin
        @(negedge i_clk);
        x = epin(c, pd, w[2]);
        chk("serial", {bst, bd}, {!w[1], w[0]});
        chk("drive", oe_n, 7'(~(7'(x[1]) << p)));
        chk("lvl", lv[p] & x[1], x[0]);
        @(posedge i_clk);
        bus(1'b1, 8'h72, e);
        pd = 32'h0;
      end
      bus(1'b0, 8'h72, 32'h0);
      chk("flags clear", sn, 32'h0);
    end
    bus(1'b1, 8'h7D, 32'h0000_0080);
    s <= 6'h01;
    f <= 3'b100;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    chk("gated", {oe_n[0], q[0], run}, 3'h0);
    $display("test pins done");
    tally_and_finish();
  end
endmodule
